// ==== pcs_map.svh ====
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// master control field layout
`define PCS_MC_HS_BIT      0
`define PCS_MC_RW_BIT      1
`define PCS_MC_LAST_BIT    2
`define PCS_MC_ELEM_LSB    3
`define PCS_MC_ELEM_MSB    5

// drive status field layout
`define PCS_DS_HS_BIT      0
`define PCS_DS_BUSY_BIT    1
`define PCS_DS_ERR_BIT     2
`define PCS_DS_CHG_BIT     5

// data block elements
`define PCS_ELEM_IDN       3'h1
`define PCS_ELEM_OPDATA    3'h7

// control value that opens the channel for a procedure command
`define PCS_OPEN_CTRL      6'h0f

// procedure command identifiers
`define PCS_IDN_CMD0       16'h007f
`define PCS_IDN_CMD1       16'h0080

// procedure command acknowledgement bits
`define PCS_ACK_SET_BIT    0
`define PCS_ACK_EN_BIT     1
`define PCS_ACK_PEND_BIT   2
`define PCS_ACK_ERR_BIT    3

// reset values
`define PCS_RST_STAT       6'h00
`define PCS_RST_INFO       16'h0000

// timing
`define PCS_CLK_NS         100
`define PCS_COMM_CYCLE_NS  1000
`define PCS_COMM_CYCLE_CLKS (`PCS_COMM_CYCLE_NS / `PCS_CLK_NS)
`define PCS_EXEC_CYCLES    4

`endif

// ==== pcs_pkg.sv ====
package pcs_pkg;

    typedef enum logic [1:0] {
        PCS_CMD_CANCEL    = 2'b00,
        PCS_CMD_INTERRUPT = 2'b01,
        PCS_CMD_RSVD      = 2'b10,
        PCS_CMD_SET_EN    = 2'b11
    } pcs_cmd_e;

    typedef enum logic {
        PCS_DP_IDLE  = 1'b0,
        PCS_DP_APPLY = 1'b1
    } pcs_dev_phase_e;

    typedef enum logic {
        PCS_MS_IDLE = 1'b0,
        PCS_MS_WAIT = 1'b1
    } pcs_mst_state_e;

    typedef logic [5:0]  pcs_field_t;
    typedef logic [15:0] pcs_info_t;

endpackage : pcs_pkg

// ==== pcs_link_if.sv ====
`timescale 1ns/1ns
interface pcs_link_if;
    import pcs_pkg::*;
    logic       mst_strobe;
    pcs_field_t mst_ctrl;
    pcs_info_t  mst_info;
    logic       drv_strobe;
    pcs_field_t drv_stat;
    pcs_info_t  drv_info;

    modport dev (
        input  mst_strobe,
        input  mst_ctrl,
        input  mst_info,
        output drv_strobe,
        output drv_stat,
        output drv_info
    );

    modport mst (
        output mst_strobe,
        output mst_ctrl,
        output mst_info,
        input  drv_strobe,
        input  drv_stat,
        input  drv_info
    );
endinterface : pcs_link_if

// ==== pcs_drive.sv ====
`timescale 1ns/1ns
`include "pcs_map.svh"

module pcs_drive
    import pcs_pkg::*;
#(
    parameter int        N_CMD       = 2,
    parameter logic [31:0] CMD_IDNS  = {`PCS_IDN_CMD1, `PCS_IDN_CMD0},
    parameter int        EXEC_CYCLES = `PCS_EXEC_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    pcs_link_if.dev               link,
    input  wire logic [N_CMD-1:0] proc_fail,
    output logic [N_CMD-1:0]      proc_running,
    output logic [N_CMD-1:0]      proc_finished,
    output logic [N_CMD-1:0]      proc_failed
);

    generate
        if (N_CMD < 1 || N_CMD > 2 || EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin : g_bad
            $error("pcs_drive: unsupported parameter value");
        end
    endgenerate

    localparam int IDXW = (N_CMD > 1) ? $clog2(N_CMD) : 1;

    // decoded master telegram fields
    logic       master_handshake_bit;
    logic       rw_write;
    logic       last_xfer;
    logic [2:0] elem;
    logic       new_step;

    assign master_handshake_bit       = link.mst_ctrl[`PCS_MC_HS_BIT];
    assign rw_write  = link.mst_ctrl[`PCS_MC_RW_BIT];
    assign last_xfer = link.mst_ctrl[`PCS_MC_LAST_BIT];
    assign elem      = link.mst_ctrl[`PCS_MC_ELEM_MSB:`PCS_MC_ELEM_LSB];

    // reply registers and step sequencing state
    logic             hs_q;
    logic             busy_q;
    logic             err_q;
    logic             chg_q;
    pcs_info_t        info_q;
    logic             strobe_q;
    pcs_dev_phase_e   phase_q;
    logic             open_q;
    logic [IDXW-1:0]  sel_q;
    pcs_cmd_e         cmd_q;
    logic             apply_stb;

    // per command state
    logic [N_CMD-1:0] set_q;
    logic [N_CMD-1:0] en_q;
    logic [N_CMD-1:0] done_q;
    logic [N_CMD-1:0] fail_q;
    logic [N_CMD-1:0] change_q;
    logic [N_CMD-1:0] change_d;
    logic [N_CMD-1:0] idn_hit;
    logic [3:0]       ack [N_CMD];

    assign new_step  = link.mst_strobe && (master_handshake_bit != hs_q);
    assign apply_stb = link.mst_strobe && (phase_q == PCS_DP_APPLY);

    // identifier match; first matching entry wins
    logic             hit_any;
    logic [IDXW-1:0]  hit_idx;
    always_comb begin
        hit_any = 1'b0;
        hit_idx = '0;
        for (int i = N_CMD - 1; i >= 0; i--) begin
            if (idn_hit[i]) begin
                hit_any = 1'b1;
                hit_idx = IDXW'(i);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_CMD; g++) begin : g_cmd
            logic [7:0] cnt_q;
            logic       sel_me;
            logic       finish;

            assign idn_hit[g] = (link.mst_info == CMD_IDNS[16*g +: 16]);
            assign sel_me     = open_q && (sel_q == IDXW'(g));
            assign finish     = link.mst_strobe && set_q[g] && en_q[g] && !done_q[g]
                                && (cnt_q == 8'(EXEC_CYCLES - 1));

            assign ack[g][`PCS_ACK_SET_BIT]  = set_q[g];
            assign ack[g][`PCS_ACK_EN_BIT]   = en_q[g];
            assign ack[g][`PCS_ACK_PEND_BIT] = set_q[g] && !done_q[g];
            assign ack[g][`PCS_ACK_ERR_BIT]  = done_q[g] && fail_q[g];

            // execution progress, counted in communication cycles
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    cnt_q <= 8'h00;
                end else if (apply_stb && sel_me && cmd_q == PCS_CMD_CANCEL) begin
                    cnt_q <= 8'h00;
                end else if (link.mst_strobe && set_q[g] && en_q[g] && !done_q[g]) begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end

            // set and enable state, changed only at the apply step
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    set_q[g] <= 1'b0;
                    en_q[g]  <= 1'b0;
                end else if (apply_stb && sel_me) begin
                    case (cmd_q)
                        PCS_CMD_SET_EN: begin
                            set_q[g] <= 1'b1;
                            en_q[g]  <= 1'b1;
                        end
                        PCS_CMD_INTERRUPT: begin
                            en_q[g] <= 1'b0;
                        end
                        PCS_CMD_CANCEL: begin
                            set_q[g] <= 1'b0;
                            en_q[g]  <= 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end

            // completion and outcome
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    done_q[g] <= 1'b0;
                    fail_q[g] <= 1'b0;
                end else if (finish) begin
                    done_q[g] <= 1'b1;
                    fail_q[g] <= proc_fail[g];
                end else if (apply_stb && sel_me && cmd_q == PCS_CMD_CANCEL) begin
                    done_q[g] <= 1'b0;
                    fail_q[g] <= 1'b0;
                end
            end

            // change flag: completion wins over a cancel in the same cycle
            always_comb begin
                if (finish) begin
                    change_d[g] = 1'b1;
                end else if (apply_stb && sel_me && cmd_q == PCS_CMD_CANCEL) begin
                    change_d[g] = 1'b0;
                end else begin
                    change_d[g] = change_q[g];
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    change_q[g] <= 1'b0;
                end else begin
                    change_q[g] <= change_d[g];
                end
            end

            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    proc_running[g]  <= 1'b0;
                    proc_finished[g] <= 1'b0;
                    proc_failed[g]   <= 1'b0;
                end else begin
                    proc_running[g]  <= set_q[g] && en_q[g] && !done_q[g];
                    proc_finished[g] <= done_q[g] && !fail_q[g];
                    proc_failed[g]   <= done_q[g] && fail_q[g];
                end
            end
        end
    endgenerate

    // which procedure command the channel is opened for
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            open_q <= 1'b0;
            sel_q  <= '0;
        end else if (new_step && phase_q == PCS_DP_IDLE && rw_write && last_xfer
                     && elem == `PCS_ELEM_IDN) begin
            open_q <= hit_any;
            sel_q  <= hit_idx;
        end
    end

    // step sequencing: control writes take one extra cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_q <= PCS_DP_IDLE;
            cmd_q   <= PCS_CMD_CANCEL;
        end else if (apply_stb) begin
            phase_q <= PCS_DP_IDLE;
        end else if (new_step && phase_q == PCS_DP_IDLE && open_q && rw_write
                     && elem == `PCS_ELEM_OPDATA) begin
            phase_q <= PCS_DP_APPLY;
            cmd_q   <= pcs_cmd_e'(link.mst_info[1:0]);
        end
    end

    // handshake, busy, error and info of the reply
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs_q   <= 1'b0;
            busy_q <= 1'b0;
            err_q  <= 1'b0;
            info_q <= `PCS_RST_INFO;
        end else if (apply_stb) begin
            busy_q <= 1'b0;
        end else if (new_step && phase_q == PCS_DP_IDLE) begin
            hs_q <= master_handshake_bit;
            if (rw_write && elem == `PCS_ELEM_OPDATA && open_q) begin
                busy_q <= 1'b1;
                err_q  <= 1'b0;
            end else if (rw_write && elem == `PCS_ELEM_IDN && hit_any) begin
                info_q <= {12'h000, ack[hit_idx]};
                err_q  <= ack[hit_idx][`PCS_ACK_ERR_BIT];
            end else if (!rw_write && elem == `PCS_ELEM_OPDATA && open_q) begin
                info_q <= {12'h000, ack[sel_q]};
                err_q  <= ack[sel_q][`PCS_ACK_ERR_BIT];
            end else begin
                info_q <= `PCS_RST_INFO;
                err_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chg_q    <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            // next value, so the cancel reply already shows the bit clear
            chg_q    <= |change_d;
            strobe_q <= link.mst_strobe;
        end
    end

    assign link.drv_strobe = strobe_q;
    assign link.drv_info   = info_q;
    assign link.drv_stat   = {chg_q, 2'b00, err_q, busy_q, hs_q};

endmodule : pcs_drive

// ==== pcs_master.sv ====
`timescale 1ns/1ns
`include "pcs_map.svh"

module pcs_master
    import pcs_pkg::*;
#(
    parameter int CYCLE_CLKS = `PCS_COMM_CYCLE_CLKS
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    pcs_link_if.mst         link,
    input  wire logic       req_valid,
    output logic            req_ready,
    input  wire logic [2:0] req_elem,
    input  wire logic       req_last,
    input  wire logic       req_write,
    input  wire pcs_info_t  req_info,
    output logic            resp_valid,
    output pcs_field_t      resp_stat,
    output pcs_info_t       resp_info
);

    generate
        if (CYCLE_CLKS < 2 || CYCLE_CLKS > 65535) begin : g_bad
            $error("pcs_master: unsupported cycle length");
        end
    endgenerate

    logic [15:0]    div_q;
    logic           tick;
    pcs_mst_state_e state_q;
    logic           mhs_q;
    pcs_field_t     ctrl_q;
    pcs_info_t      info_q;
    pcs_field_t     link_ctrl_q;
    pcs_info_t      link_info_q;
    logic           strobe_q;

    assign tick      = (div_q == 16'(CYCLE_CLKS - 1));
    assign req_ready = (state_q == PCS_MS_IDLE);

    // communication cycle divider
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= 16'h0000;
        end else if (tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // step request: new handshake value presents a new step
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= PCS_MS_IDLE;
            mhs_q   <= 1'b0;
            ctrl_q  <= `PCS_RST_STAT;
            info_q  <= `PCS_RST_INFO;
        end else if (state_q == PCS_MS_IDLE && req_valid) begin
            state_q <= PCS_MS_WAIT;
            mhs_q   <= ~mhs_q;
            ctrl_q  <= {req_elem, req_last, req_write, ~mhs_q};
            info_q  <= req_info;
        end else if (state_q == PCS_MS_WAIT && link.drv_strobe
                     && link.drv_stat[`PCS_DS_HS_BIT] == mhs_q
                     && !link.drv_stat[`PCS_DS_BUSY_BIT]) begin
            state_q <= PCS_MS_IDLE;
        end
    end

    // telegram launch once per communication cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link_ctrl_q <= `PCS_RST_STAT;
            link_info_q <= `PCS_RST_INFO;
            strobe_q    <= 1'b0;
        end else begin
            strobe_q <= tick;
            if (tick) begin
                link_ctrl_q <= ctrl_q;
                link_info_q <= info_q;
            end
        end
    end

    // answer capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resp_valid <= 1'b0;
            resp_stat  <= `PCS_RST_STAT;
            resp_info  <= `PCS_RST_INFO;
        end else begin
            resp_valid <= state_q == PCS_MS_WAIT && link.drv_strobe
                          && link.drv_stat[`PCS_DS_HS_BIT] == mhs_q
                          && !link.drv_stat[`PCS_DS_BUSY_BIT];
            if (link.drv_strobe) begin
                resp_stat <= link.drv_stat;
                resp_info <= link.drv_info;
            end
        end
    end

    assign link.mst_strobe = strobe_q;
    assign link.mst_ctrl   = link_ctrl_q;
    assign link.mst_info   = link_info_q;

endmodule : pcs_master

// ==== pcs_link_props.sv ====
`timescale 1ns/1ns
module pcs_link_props
    import pcs_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       mst_strobe,
    input wire pcs_field_t mst_ctrl,
    input wire pcs_info_t  mst_info,
    input wire logic       drv_strobe,
    input wire pcs_field_t drv_stat,
    input wire pcs_info_t  drv_info
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence busy_reply_s;
        drv_strobe && drv_stat[1];
    endsequence
    sequence idle_reply_s;
        drv_strobe && !drv_stat[1];
    endsequence
    sequence open_req_s;
        mst_strobe && mst_ctrl[5:1] == 5'h07 && mst_ctrl[0] != drv_stat[0]
            && (mst_info == 16'h007f || mst_info == 16'h0080);
    endsequence

    reply_follows_a: assert property (mst_strobe |=> drv_strobe)
        else $error("drive reply missing after master telegram");
    strobe_gap_a: assert property (mst_strobe |=> !mst_strobe [*3])
        else $error("master telegrams closer than one comm cycle");
    reserved_bits_a: assert property (drv_strobe |-> drv_stat[4:3] == 2'h0)
        else $error("reserved status bits not zero");
    busy_status_a: assert property (busy_reply_s |->
        drv_stat[4:1] == 4'h1 && drv_stat[0] == $past(mst_ctrl[0]))
        else $error("busy reply status wrong");
    apply_next_a: assert property (busy_reply_s |-> ##[1:8] idle_reply_s)
        else $error("control not applied in next cycle");
    open_ack_a: assert property (open_req_s |=> drv_strobe && !drv_stat[1]
        && drv_stat[0] == $past(mst_ctrl[0]) && drv_info[15:4] == 12'h000)
        else $error("open not answered with ack and echo");
    err_ack_a: assert property (drv_strobe && drv_stat[2] |-> drv_info[3:0] == 4'hb)
        else $error("error bit without negative ack");
    pend_set_a: assert property (drv_strobe && drv_info[2] |->
        drv_info[0] && !drv_info[3])
        else $error("pending ack without set");
endmodule : pcs_link_props

// ==== procedure_command_service_channel_test.sv ====
`timescale 1ns/1ns
module procedure_command_service_channel_test;
    import pcs_pkg::*;
    logic       clk;
    logic       sys_rst;
    logic       req_valid;
    logic       req_ready;
    logic [2:0] req_elem;
    logic       req_last;
    logic       req_write;
    pcs_info_t  req_info;
    logic       resp_valid;
    pcs_field_t resp_stat;
    pcs_info_t  resp_info;
    logic [1:0] proc_fail;
    logic [1:0] proc_running;
    logic [1:0] proc_finished;
    logic [1:0] proc_failed;
    logic       hs;
    int         failures;
    int         samples_checked;

    pcs_link_if link ();

    pcs_master #(.CYCLE_CLKS(4)) i_pcs_master (
        .clk(clk), .sys_rst(sys_rst), .link(link.mst),
        .req_valid(req_valid), .req_ready(req_ready), .req_elem(req_elem),
        .req_last(req_last), .req_write(req_write), .req_info(req_info),
        .resp_valid(resp_valid), .resp_stat(resp_stat), .resp_info(resp_info)
    );

    // long execution so an interrupt lands before completion
    pcs_drive #(.EXEC_CYCLES(20)) i_pcs_drive (
        .clk(clk), .sys_rst(sys_rst), .link(link.dev), .proc_fail(proc_fail),
        .proc_running(proc_running), .proc_finished(proc_finished),
        .proc_failed(proc_failed)
    );

    pcs_link_props i_pcs_link_props (
        .clk(clk), .sys_rst(sys_rst),
        .mst_strobe(link.mst_strobe), .mst_ctrl(link.mst_ctrl), .mst_info(link.mst_info),
        .drv_strobe(link.drv_strobe), .drv_stat(link.drv_stat), .drv_info(link.drv_info)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task finish_test;
        $display("counts: %0d mismatches in %0d checks", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task give_up;
        failures++;
        $display("mismatch at %0t: wait ran out", $time);
        finish_test();
    endtask : give_up

    // one service channel step through the master, checked on link and reply
    task step(input logic [2:0] e, input logic w, input pcs_info_t i, input logic ci,
              input logic [3:0] ack, input logic chg, input logic err);
        int n;
        hs = ~hs;
        req_valid = 1'b1;
        req_elem = e;
        req_write = w;
        req_last = 1'b1;
        req_info = i;
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 50) give_up();
        end
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        // a telegram launched on the request edge still carries the previous step
        while (!(link.mst_strobe === 1'b1 && link.mst_ctrl[0] === hs)) begin
            @(negedge clk);
            n++;
            if (n > 50) give_up();
        end
        chk({10'h000, link.mst_ctrl}, {10'h000, e, 1'b1, w, hs});
        chk(link.mst_info, i);
        n = 0;
        while (resp_valid !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 100) give_up();
        end
        chk({10'h000, resp_stat}, {10'h000, chg, 2'b00, err, 1'b0, hs});
        if (ci)
            chk(resp_info, {12'h000, ack});
        @(negedge clk);
    endtask : step

    task wait_done(input int k);
        int n;
        n = 0;
        while (proc_running[k] === 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 400) give_up();
        end
        @(negedge clk);
    endtask : wait_done

    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req_elem = 3'h0;
        req_last = 1'b0;
        req_write = 1'b0;
        req_info = 16'h0000;
        proc_fail = 2'b00;
        hs = 1'b0;
        failures = 0;
        samples_checked = 0;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        step(3'h1, 1'b1, 16'h007f, 1'b1, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b1, 16'h0003, 1'b0, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b0, 16'h0000, 1'b1, 4'h7, 1'b0, 1'b0);
        step(3'h3, 1'b1, 16'h1234, 1'b1, 4'h0, 1'b0, 1'b0);
        wait_done(0);
        chk({14'h0000, proc_finished[0], proc_failed[0]}, 16'h0002);
        step(3'h7, 1'b0, 16'h0000, 1'b1, 4'h3, 1'b1, 1'b0);
        step(3'h7, 1'b1, 16'h0000, 1'b0, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b0, 16'h0000, 1'b1, 4'h0, 1'b0, 1'b0);
        proc_fail = 2'b10;
        step(3'h1, 1'b1, 16'h0080, 1'b1, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b1, 16'h0003, 1'b0, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b1, 16'h0001, 1'b0, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b0, 16'h0000, 1'b1, 4'h5, 1'b0, 1'b0);
        repeat (100) @(negedge clk);
        chk({15'h0000, proc_running[1]}, 16'h0000);
        step(3'h7, 1'b1, 16'h0003, 1'b0, 4'h0, 1'b0, 1'b0);
        wait_done(1);
        chk({14'h0000, proc_finished[1], proc_failed[1]}, 16'h0001);
        step(3'h7, 1'b0, 16'h0000, 1'b1, 4'hb, 1'b1, 1'b1);
        step(3'h7, 1'b1, 16'h0000, 1'b0, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b0, 16'h0000, 1'b1, 4'h0, 1'b0, 1'b0);
        step(3'h1, 1'b1, 16'h0055, 1'b1, 4'h0, 1'b0, 1'b0);
        proc_fail = 2'b00;
        step(3'h1, 1'b1, 16'h0080, 1'b1, 4'h0, 1'b0, 1'b0);
        step(3'h7, 1'b1, 16'h0003, 1'b0, 4'h0, 1'b0, 1'b0);
        wait_done(1);
        chk({14'h0000, proc_finished[1], proc_failed[1]}, 16'h0002);
        step(3'h7, 1'b0, 16'h0000, 1'b1, 4'h3, 1'b1, 1'b0);
        finish_test();
    end
endmodule : procedure_command_service_channel_test
